//--- inc/vcbc_pkg.sv
// Package: constants and carrier types of the capture buffer control block
package vcbc_pkg;

	// Register word offsets (byte addresses)
	localparam logic [7:0]  VCBC_OFS_CTRL   = 8'h00;
	localparam logic [7:0]  VCBC_OFS_OVL    = 8'h04;
	localparam logic [7:0]  VCBC_OFS_BUF1   = 8'h08;
	localparam logic [7:0]  VCBC_OFS_BUF2   = 8'h0C;
	localparam logic [7:0]  VCBC_OFS_WSRC   = 8'h10;
	localparam logic [7:0]  VCBC_OFS_STAT   = 8'h14;
	localparam logic [7:0]  VCBC_OFS_PIXCNT = 8'h18;

	// Field positions of capture_control_reg
	localparam int          VCBC_CTL_EN     = 0;
	localparam int          VCBC_CTL_F1     = 1;
	localparam int          VCBC_CTL_F2     = 2;
	localparam int          VCBC_CTL_COND   = 8;
	localparam int          VCBC_CTL_DBL    = 9;
	localparam int          VCBC_CTL_ILACE  = 10;
	localparam int          VCBC_CTL_SKIP_L = 11;
	// Field position of overlay_misc_control_reg
	localparam int          VCBC_OVL_AUTO   = 24;

	// Frame-skip codes
	localparam logic [2:0]  VCBC_SKIP_EVEN  = 3'h2;
	localparam logic [2:0]  VCBC_SKIP_ODD   = 3'h3;

	typedef enum logic {
		VCBC_ST_IDLE,
		VCBC_ST_CAPTURE
	} vcbc_st_t;

	// Wishbone classic request from the master
	typedef struct packed {
		logic        cyc;
		logic        stb;
		logic        we;
		logic [3:0]  sel;
		logic [7:0]  adr;
		logic [31:0] dat;
	} vcbc_wb_req_t;

	// Commands to the capture write path
	typedef struct packed {
		logic        active;
		logic        buf_sel;
		logic        interleave;
		logic [31:0] base;
	} vcbc_cap_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic        enable;
		logic        f1;
		logic        f2;
		logic        cond;
		logic        dbl;
		logic        ilace;
		logic [2:0]  skip;
		logic        auto_disp;
		logic [31:0] buf1;
		logic [31:0] buf2;
		logic [31:0] wsrc;
		vcbc_st_t    st;
		logic        cur;
		logic [2:0]  skip_cnt;
		logic [15:0] frames;
		logic        vref_smp;
		logic [15:0] pix_cnt;
		logic [15:0] pix_last;
		logic [31:0] cap_base;
		logic [31:0] ovl_addr;
	} vcbc_state_t;

	// Everything clears at reset: capture off, both flags 0, single continuous mode
	localparam vcbc_state_t VCBC_STATE_RST = '0;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
	} vcbc_edge_state_t;

	localparam vcbc_edge_state_t VCBC_EDGE_RST = '0;

endpackage : vcbc_pkg

//--- rtl/vcbc_edge.sv
// Two-flop synchroniser with rising edge detector for a pin input
`timescale 1ns/1ps
module vcbc_edge (
	// Clock and reset
	input  wire logic SYS_CLK,
	input  wire logic RST,
	input  wire logic CE,
	// Pin and result
	input  wire logic PIN,
	output logic      LEVEL,
	output logic      RISE
);
	import vcbc_pkg::*;

	vcbc_edge_state_t s_ff;
	vcbc_edge_state_t nxt_s;

	always_comb begin
		nxt_s    = s_ff;
		nxt_s.s1 = PIN;
		nxt_s.s2 = s_ff.s1;
		nxt_s.s3 = s_ff.s2;
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			s_ff <= VCBC_EDGE_RST;
		end else if (CE) begin
			s_ff <= nxt_s;
		end
	end

	// The first flop feeds only the second one
	assign LEVEL = s_ff.s2;
	assign RISE  = s_ff.s2 & ~s_ff.s3;

endmodule : vcbc_edge

//--- rtl/vcbc_top.sv
// Capture buffer control: buffer selection, status flags, overlay address, Wishbone registers
`timescale 1ns/1ps
module vcbc_top (
	// Clock, reset, enable
	input  wire logic                   SYS_CLK,
	input  wire logic                   RST,
	input  wire logic                   CE,
	// Wishbone classic slave
	input  wire vcbc_pkg::vcbc_wb_req_t WB_REQ,
	output logic                        WB_ACK_O,
	output logic [31:0]                 WB_DAT_O,
	// Video port pins
	input  wire logic                   PCLK,
	input  wire logic                   VREF,
	// Capture write path and overlay
	output vcbc_pkg::vcbc_cap_t         CAP,
	output logic [31:0]                 OVL_ADDR
);
	import vcbc_pkg::*;

	vcbc_state_t s_ff;
	vcbc_state_t nxt_s;
	logic        pclk_rise;
	logic        vref_lvl;
	logic        fr_edge;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] dat,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = dat[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic [31:0] ctrl_image(input vcbc_state_t s);
		logic [31:0] r;
		r = 32'h0000_0000;
		r[VCBC_CTL_EN]                 = s.enable;
		r[VCBC_CTL_F1]                 = s.f1;
		r[VCBC_CTL_F2]                 = s.f2;
		r[VCBC_CTL_COND]               = s.cond;
		r[VCBC_CTL_DBL]                = s.dbl;
		r[VCBC_CTL_ILACE]              = s.ilace;
		r[VCBC_CTL_SKIP_L +: 3]        = s.skip;
		return r;
	endfunction : ctrl_image

	// Whether the incoming frame is kept by the skip setting
	function automatic logic skip_keep(input logic [2:0] code, input logic odd, input logic [2:0] cnt);
		logic k;
		k = 1'b1;
		if (code == VCBC_SKIP_EVEN) begin
			k = odd;
		end else if (code == VCBC_SKIP_ODD) begin
			k = ~odd;
		end else if (code[2]) begin
			k = (cnt == 3'h0);
		end
		return k;
	endfunction : skip_keep

	function automatic logic [31:0] buf_base(input vcbc_state_t s, input logic sel);
		return sel ? s.buf2 : s.buf1;
	endfunction : buf_base

	// A selected low byte lane hands both flags to software: its write, 1 or 0, beats a clear
	// by the capture unit in the same cycle; with the lane off the hardware value is kept
	function automatic logic flag_merge(input logic lane0, input logic wbit, input logic hw);
		return lane0 ? wbit : hw;
	endfunction : flag_merge

	// Overlay window one source: programmed address, or the buffer not being filled in double mode, else buffer one
	function automatic logic [31:0] ovl_source(input vcbc_state_t s);
		logic [31:0] a;
		if (!s.auto_disp) begin
			a = s.wsrc;
		end else if (s.dbl) begin
			a = buf_base(s, ~s.cur);
		end else begin
			a = s.buf1;
		end
		return a;
	endfunction : ovl_source

	////////////////////////////////////////////////////////////////////////////////
	// Pin sampling

	vcbc_edge u_pclk (
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.CE      (CE),
		.PIN     (PCLK),
		.LEVEL   (),
		.RISE    (pclk_rise)
	);

	vcbc_edge u_vref (
		.SYS_CLK (SYS_CLK),
		.RST     (RST),
		.CE      (CE),
		.PIN     (VREF),
		.LEVEL   (vref_lvl),
		.RISE    ()
	);

	// VREF is taken at pixel clock edges, so glitches between them cannot end a frame
	assign fr_edge = pclk_rise & vref_lvl & ~s_ff.vref_smp;

	////////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		logic        req;
		logic        wr;
		logic        take;
		logic        rd_take;
		logic [31:0] cimg;
		logic        keep;
		logic        f1;
		logic        f2;
		logic        cur_n;
		logic        pair;
		logic        go;
		req   = WB_REQ.cyc & WB_REQ.stb;
		wr    = req & WB_REQ.we & s_ff.ack;
		take  = req & ~s_ff.ack;
		rd_take = take & ~WB_REQ.we;
		cimg  = 32'h0000_0000;
		keep  = 1'b0;
		f1    = s_ff.f1;
		f2    = s_ff.f2;
		cur_n = s_ff.cur;
		pair  = 1'b0;
		go    = 1'b0;
		nxt_s = s_ff;

		// Bus: ack one cycle after the request is seen, dropped in the following cycle
		nxt_s.ack = take;
		// Only reads load the data register, so a read result stands until the next read
		if (rd_take) begin
			unique case (WB_REQ.adr)
				VCBC_OFS_CTRL:   nxt_s.rdat = ctrl_image(s_ff);
				VCBC_OFS_OVL:    nxt_s.rdat = {7'h00, s_ff.auto_disp, 24'h00_0000};
				VCBC_OFS_BUF1:   nxt_s.rdat = s_ff.buf1;
				VCBC_OFS_BUF2:   nxt_s.rdat = s_ff.buf2;
				VCBC_OFS_WSRC:   nxt_s.rdat = s_ff.wsrc;
				VCBC_OFS_STAT:   nxt_s.rdat = {s_ff.frames, 14'h0000, s_ff.cur, s_ff.st == VCBC_ST_CAPTURE};
				VCBC_OFS_PIXCNT: nxt_s.rdat = {16'h0000, s_ff.pix_last};
				default:         nxt_s.rdat = 32'h0000_0000;
			endcase
		end

		// Pixel clocks per frame, for software to see the port is alive
		if (pclk_rise) begin
			nxt_s.vref_smp = vref_lvl;
			nxt_s.pix_cnt  = s_ff.pix_cnt + 16'h0001;
		end

		if (fr_edge) begin
			nxt_s.frames   = s_ff.frames + 16'h0001;
			nxt_s.pix_last = s_ff.pix_cnt;
			// The boundary edge is the first pixel clock of the new frame
			nxt_s.pix_cnt  = 16'h0001;
			// Frame parity is that of the count before this boundary
			keep = skip_keep(s_ff.skip, s_ff.frames[0], s_ff.skip_cnt);
			// The count runs from zero to the low code bits plus one: one frame kept per run
			if (s_ff.skip[2] && s_ff.skip_cnt <= 3'(s_ff.skip[1:0]) ) begin
				nxt_s.skip_cnt = s_ff.skip_cnt + 3'h1;
			end else begin
				nxt_s.skip_cnt = 3'h0;
			end

			// Completion of the frame just written
			// A first field pulls in its second field unless the enable has been cleared, which splits the pair
			if (s_ff.st == VCBC_ST_CAPTURE) begin
				if (s_ff.ilace) begin
					if (s_ff.cur) begin
						f1    = 1'b0;
						f2    = 1'b0;
						cur_n = 1'b0;
					end else begin
						cur_n = 1'b1;
						pair  = 1'b1;
					end
				end else if (s_ff.cond) begin
					if (s_ff.cur) begin
						f2 = 1'b0;
					end else begin
						f1 = 1'b0;
					end
					cur_n = s_ff.dbl & ~s_ff.cur;
				end else begin
					cur_n = s_ff.dbl & ~s_ff.cur;
				end
			end

			// Decide on the frame now starting
			// Clearing the enable lets the frame in flight finish, and nothing new starts
			if (!s_ff.enable) begin
				go = 1'b0;
			end else if (pair && s_ff.enable) begin
				go = 1'b1;
			end else if (s_ff.ilace) begin
				go    = keep & (f1 | f2);
				cur_n = 1'b0;
			end else if (!s_ff.cond) begin
				go = keep;
				if (!s_ff.dbl) begin
					cur_n = 1'b0;
				end
			end else if (!s_ff.dbl) begin
				go    = keep & f1;
				cur_n = 1'b0;
			end else begin
				go = keep & (f1 | f2);
				if (!(f1 & f2)) begin
					cur_n = f2;
				end
			end
			nxt_s.st       = go ? VCBC_ST_CAPTURE : VCBC_ST_IDLE;
			nxt_s.cur      = cur_n;
			nxt_s.f1       = f1;
			nxt_s.f2       = f2;
			nxt_s.cap_base = buf_base(s_ff, cur_n);
		end

		// Software writes come last so a set in the clearing cycle is kept
		if (wr) begin
			unique case (WB_REQ.adr)
				VCBC_OFS_CTRL: begin
					cimg          = wmerge(ctrl_image(s_ff), WB_REQ.dat, WB_REQ.sel);
					nxt_s.enable  = cimg[VCBC_CTL_EN];
					nxt_s.f1      = flag_merge(WB_REQ.sel[0], cimg[VCBC_CTL_F1], f1);
					nxt_s.f2      = flag_merge(WB_REQ.sel[0], cimg[VCBC_CTL_F2], f2);
					nxt_s.cond    = cimg[VCBC_CTL_COND];
					nxt_s.dbl     = cimg[VCBC_CTL_DBL];
					nxt_s.ilace   = cimg[VCBC_CTL_ILACE];
					nxt_s.skip    = cimg[VCBC_CTL_SKIP_L +: 3];
				end
				VCBC_OFS_OVL: begin
					if (WB_REQ.sel[3]) begin
						nxt_s.auto_disp = WB_REQ.dat[VCBC_OVL_AUTO];
					end
				end
				VCBC_OFS_BUF1: nxt_s.buf1 = wmerge(s_ff.buf1, WB_REQ.dat, WB_REQ.sel);
				VCBC_OFS_BUF2: nxt_s.buf2 = wmerge(s_ff.buf2, WB_REQ.dat, WB_REQ.sel);
				VCBC_OFS_WSRC: nxt_s.wsrc = wmerge(s_ff.wsrc, WB_REQ.dat, WB_REQ.sel);
				default: begin
				end
			endcase
		end

		nxt_s.ovl_addr = ovl_source(s_ff);
	end

	// CE low freezes the whole block, synchronisers included, so no pixel edge is invented
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			s_ff <= VCBC_STATE_RST;
		end else if (CE) begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign WB_ACK_O       = s_ff.ack;
	assign WB_DAT_O       = s_ff.rdat;
	assign CAP.active     = s_ff.st == VCBC_ST_CAPTURE;
	assign CAP.buf_sel    = s_ff.cur;
	assign CAP.interleave = s_ff.ilace;
	assign CAP.base       = s_ff.cap_base;
	assign OVL_ADDR       = s_ff.ovl_addr;

endmodule : vcbc_top

//--- bench/vcbc_vsrc.sv
// Video source model: pixel clock bursts framed by a vertical reference pulse
`timescale 1ns/1ps
module vcbc_vsrc (
	// Video port pins
	output logic pclk,
	output logic vref
);
	initial begin
		pclk = 1'b0;
		vref = 1'b0;
	end
	////////////////////////////////////////
	// Clock stands still between frames; the reference only moves while the clock is low
	task automatic frame;
		#137;
		vref = 1'b1;
		repeat (6) begin
			#400 pclk = 1'b1;
			#400 pclk = 1'b0;
			vref = 1'b0;
		end
	endtask : frame
endmodule : vcbc_vsrc

//--- bench/vcbc_top_properties.sv
// Checker: bus handshake and frame-boundary properties of the capture buffer control
`timescale 1ns/1ps
module vcbc_top_properties (
	// Clock, reset, enable
	input wire logic                   SYS_CLK,
	input wire logic                   RST,
	input wire logic                   CE,
	// Register bus
	input wire vcbc_pkg::vcbc_wb_req_t WB_REQ,
	input wire logic                   WB_ACK_O,
	input wire logic [31:0]            WB_DAT_O,
	// Video port and outputs
	input wire logic                   PCLK,
	input wire logic                   VREF,
	input wire vcbc_pkg::vcbc_cap_t    CAP,
	input wire logic [31:0]            OVL_ADDR
);
	import vcbc_pkg::*;
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RST);
	////////////////////////////////////////
	sequence rd_taken;
		CE && WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !WB_ACK_O;
	endsequence
	// Eight quiet cycles rule out a boundary still in the synchronisers
	sequence quiet_vref;
		(!VREF) [*8];
	endsequence
	AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
		else $error("ack held longer than one cycle");
	AST_ACK_NEXT: assert property (CE && WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O)
		else $error("request not answered in one cycle");
	AST_RD_HOLD: assert property (!(WB_REQ.cyc && WB_REQ.stb && !WB_REQ.we && !WB_ACK_O) |=> $stable(WB_DAT_O))
		else $error("read data moved without a read");
	AST_RD_UNMAPPED: assert property (rd_taken ##0 (WB_REQ.adr > 8'h18) |=> WB_DAT_O == 32'h0000_0000)
		else $error("unmapped read not zero");
	AST_RD_STATUS: assert property (rd_taken ##0 (WB_REQ.adr == VCBC_OFS_STAT) |=> WB_DAT_O[0] == $past(CAP.active))
		else $error("status capturing bit differs from capture output");
	AST_CAP_HOLD: assert property (quiet_vref |=> $stable(CAP.active) && $stable(CAP.buf_sel))
		else $error("capture state moved away from a frame boundary");
	AST_SEL_AT_VREF: assert property ($changed(CAP.buf_sel) || $changed(CAP.active) |->
		$past(VREF, 2) || $past(VREF, 3) || $past(VREF, 4) || $past(VREF, 5))
		else $error("buffer switch without vertical reference");
	AST_ILACE_PAIR: assert property ($rose(CAP.buf_sel) && CAP.interleave |-> $past(CAP.active))
		else $error("second field not preceded by first field");
endmodule : vcbc_top_properties

bind vcbc_top vcbc_top_properties vcbc_top_properties_i (.SYS_CLK(SYS_CLK), .RST(RST), .CE(CE), .WB_REQ(WB_REQ),
	.WB_ACK_O(WB_ACK_O), .WB_DAT_O(WB_DAT_O), .PCLK(PCLK), .VREF(VREF), .CAP(CAP), .OVL_ADDR(OVL_ADDR));

//--- bench/vcbc_top_tb.sv
// Testbench: register access and frame-by-frame buffer control scenarios
`timescale 1ns/1ps
module vcbc_top_tb;
	import vcbc_pkg::*;
	logic         sys_clk;
	logic         rst;
	vcbc_wb_req_t req;
	logic         ack;
	logic [31:0]  rdat;
	logic         pclk;
	logic         vref;
	vcbc_cap_t    cap;
	logic [31:0]  ovl;
	logic [31:0]  q;
	int           n_mismatch;
	int           checks_done;
	int           cyc_n = 0;
	vcbc_top vcbc_top_i (.SYS_CLK(sys_clk), .RST(rst), .CE(1'b1), .WB_REQ(req), .WB_ACK_O(ack),
		.WB_DAT_O(rdat), .PCLK(pclk), .VREF(vref), .CAP(cap), .OVL_ADDR(ovl));
	vcbc_vsrc vcbc_vsrc_i (.pclk(pclk), .vref(vref));
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end
	////////////////////////////////////////
	task automatic chk(input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge sys_clk);
		req <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'hF, adr: a, dat: d};
		do begin
			@(posedge sys_clk);
			n++;
		end while (ack !== 1'b1 && n < 40);
		q = rdat;
		req <= '0;
		if (ack !== 1'b1) begin
			n_mismatch++;
			$display("ERROR t=%0t exp=%h got=%h", $time, 1'b1, ack);
		end
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk(e, q);
	endtask : rd
	// Idle capture compares as zero whatever buffer it last pointed at
	task automatic fr(input logic [2:0] e);
		vcbc_vsrc_i.frame();
		chk(32'(e), cap.active ? 32'({1'b1, cap.buf_sel, cap.interleave}) : 32'h0000_0000);
	endtask : fr
	////////////////////////////////////////
	task automatic t_regs;
		rd(VCBC_OFS_CTRL, 32'h0000_0000);
		rd(VCBC_OFS_OVL, 32'h0000_0000);
		wb(1'b1, VCBC_OFS_BUF1, 32'h0000_1000);
		wb(1'b1, VCBC_OFS_BUF2, 32'h0000_2000);
		wb(1'b1, VCBC_OFS_WSRC, 32'h0000_3000);
		rd(8'h1C, 32'h0000_0000);
		chk(32'h0000_3000, ovl);
	endtask : t_regs
	task automatic t_single;
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0001);
		fr(3'h4);
		fr(3'h4);
		chk(32'h0000_1000, cap.base);
		rd(VCBC_OFS_PIXCNT, 32'h0000_0006);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0000);
		fr(3'h0);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0103);
		fr(3'h4);
		fr(3'h0);
		rd(VCBC_OFS_CTRL, 32'h0000_0101);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0103);
		fr(3'h4);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0006);
		fr(3'h0);
	endtask : t_single
	task automatic t_dbl;
		wb(1'b1, VCBC_OFS_OVL, 32'h0100_0000);
		rd(VCBC_OFS_OVL, 32'h0100_0000);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0201);
		vcbc_vsrc_i.frame();
		for (int i = 0; i < 3; i++) begin
			fr({1'b1, !cap.buf_sel, 1'b0});
			chk(cap.buf_sel ? 32'h0000_1000 : 32'h0000_2000, ovl);
			chk(cap.buf_sel ? 32'h0000_2000 : 32'h0000_1000, cap.base);
		end
		wb(1'b1, VCBC_OFS_OVL, 32'h0000_0000);
		// The frame in flight ends in buffer two under the new mode, which clears its flag
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0305);
		fr(3'h0);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0305);
		fr(3'h6);
		fr(3'h0);
		rd(VCBC_OFS_CTRL, 32'h0000_0301);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0307);
		fr(3'h4);
		fr(3'h6);
		fr(3'h0);
		rd(VCBC_OFS_CTRL, 32'h0000_0301);
	endtask : t_dbl
	task automatic t_skip;
		logic a;
		// Codes 010 and 011 keep by frame parity, 100 keeps one frame in two by count
		for (int k = 2; k < 5; k++) begin
			wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0001 | (32'(k) << VCBC_CTL_SKIP_L));
			vcbc_vsrc_i.frame();
			a = cap.active;
			vcbc_vsrc_i.frame();
			chk(32'h0000_0001, 32'(a ^ cap.active));
		end
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0000);
		fr(3'h0);
	endtask : t_skip
	task automatic t_ilace;
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0607);
		fr(3'h5);
		wb(1'b0, VCBC_OFS_STAT, 32'h0000_0000);
		chk(32'h0000_0001, 32'(q[1:0]));
		fr(3'h7);
		fr(3'h0);
		rd(VCBC_OFS_CTRL, 32'h0000_0601);
		wb(1'b1, VCBC_OFS_CTRL, 32'h0000_0607);
		fr(3'h5);
	endtask : t_ilace
	// Reset in mid-run, with capture active: registers and outputs return to zero
	task automatic t_reset;
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		chk(32'h0000_0000, ovl);
		rd(VCBC_OFS_STAT, 32'h0000_0000);
		rd(VCBC_OFS_CTRL, 32'h0000_0000);
	endtask : t_reset
	task automatic finish_test;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : finish_test
	////////////////////////////////////////
	always @(posedge sys_clk) begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 10000) begin
			n_mismatch++;
			finish_test();
		end
	end
	initial begin
		rst = 1'b1;
		req = '0;
		n_mismatch = 0;
		checks_done = 0;
		repeat (5) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_single();
		t_dbl();
		t_skip();
		t_ilace();
		t_reset();
		finish_test();
	end
endmodule : vcbc_top_tb
